// ### rtl/slcc_pkg.sv
// Constants shared by the serial link channel control block.
package slcc_pkg;
	// Command field layout (16 bits, right justified in the 32-bit word).
	localparam int          CMD_W           = 16;
	localparam int          CMD_IGNORE_BIT  = 31;
	localparam int          CMD_XFER_BIT    = 12;
	localparam int          CMD_STARTSTOP   = 11;
	localparam int          MASK_W          = 8;
	localparam logic [15:0] CMD_HALT_ALL    = 16'h0800;
	localparam logic [3:0]  CMD_TYPE_STOP   = 4'h8;
	localparam logic [3:0]  CMD_TYPE_NORMAL = 4'h9;
	localparam logic [3:0]  CMD_TYPE_SETUP  = 4'hF;

	// Register map: byte addresses on the plain register port.
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFF_COMMAND     = 8'h00;
	localparam logic [7:0]  OFF_DATA        = 8'h04;
	localparam logic [7:0]  OFF_CHAN_BASE   = 8'h40;
	localparam int          CHAN_STRIDE_LOG = 4;
	localparam logic [3:0]  OFF_XFER_WORD0  = 4'h0;
	localparam logic [3:0]  OFF_XFER_WORD1  = 4'h4;
	localparam logic [3:0]  OFF_XFER_WORD2  = 4'h8;
	localparam logic [3:0]  OFF_CTRL_STAT   = 4'hC;

	// Reset values.
	localparam logic [15:0] RST_COMMAND     = 16'h0000;
	localparam logic [7:0]  RST_DATA        = 8'h00;
	localparam logic [31:0] RST_WORD        = 32'h0000_0000;
	localparam logic [7:0]  RST_BYTE        = 8'h00;

	// Control/status word byte positions and status byte flag positions.
	localparam int          CS_FAR_LSB      = 24;
	localparam int          CS_STATE_LSB    = 16;
	localparam int          CS_STATUS_LSB   = 8;
	localparam int          CS_LOCAL_LSB    = 0;
	localparam int          ST_NOT_READY    = 7;
	localparam int          ST_NO_IDENT     = 6;
	localparam int          ST_LINK_ERROR   = 5;
	localparam int          ST_FAR_FAULT    = 0;

	// Engine revision from which the far fault byte is valid right after start.
	localparam int          REV_FAR_AT_START = 29;

	// Process contents table: two-byte entries, ended by a zero pointer.
	localparam int          TABLE_ENTRY_BYTES = 2;
	localparam logic [15:0] TABLE_SENTINEL    = 16'h0000;

	// Command completion timeout.
	localparam int          CLK_MHZ          = 25;
	localparam int          CMD_TIMEOUT_US   = 1000;
	localparam int          CMD_TIMEOUT_CYC  = CMD_TIMEOUT_US * CLK_MHZ;

	typedef enum logic [1:0] {
		CMD_IDLE  = 2'b00,
		CMD_START = 2'b01,
		CMD_XFER  = 2'b10
	} slcc_state_t;
endpackage : slcc_pkg

// ### rtl/slcc_channel_control.sv
// Command interpreter and per-channel registers of the serial link engine.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
module slcc_channel_control #(
	parameter int CHANNELS       = 8,
	parameter int ENGINE_REV     = slcc_pkg::REV_FAR_AT_START,
	parameter int TIMEOUT_CYCLES = slcc_pkg::CMD_TIMEOUT_CYC
) (
	input  wire logic                     sys_clk,
	input  wire logic                     srst,
	input  wire logic [7:0]               reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [31:0]              reg_rdata,
	output logic      [CHANNELS-1:0]      link_start,
	output logic                          link_setup_mode,
	output logic                          link_discover,
	output logic      [CHANNELS-1:0]      link_xfer,
	output logic      [CHANNELS-1:0]      link_stop,
	output logic      [CHANNELS*96-1:0]   link_tx_data,
	output logic      [CHANNELS*8-1:0]    link_mode,
	input  wire logic [CHANNELS-1:0]      link_done,
	input  wire logic [CHANNELS-1:0]      link_ok,
	input  wire logic [CHANNELS*96-1:0]   link_rx_data,
	input  wire logic [CHANNELS*8-1:0]    link_state,
	input  wire logic [CHANNELS-1:0]      link_error,
	input  wire logic [CHANNELS*8-1:0]    link_fault_evt,
	input  wire logic [CHANNELS*8-1:0]    link_far_fault
);

	localparam logic [31:0] TMO_LAST = 32'(TIMEOUT_CYCLES - 1);
	localparam logic        FAR_AT_START = (ENGINE_REV >= slcc_pkg::REV_FAR_AT_START);

	if (CHANNELS < 1 || CHANNELS > slcc_pkg::MASK_W) begin : g_bad_channels
		$error("CHANNELS must lie between 1 and 8");
	end
	if (TIMEOUT_CYCLES < 1) begin : g_bad_timeout
		$error("TIMEOUT_CYCLES must be at least 1");
	end

	slcc_pkg::slcc_state_t state;
	logic [15:0]          cmd_q;
	logic [7:0]           data_q;
	logic [CHANNELS-1:0]  pend;
	logic [CHANNELS-1:0]  fail;
	logic [31:0]          tmo_cnt;
	logic [CHANNELS-1:0]  active;
	logic [CHANNELS-1:0]  setup;
	logic [CHANNELS-1:0]  ident_ok;
	logic [CHANNELS-1:0]  far_valid;
	logic [31:0]          out_q [CHANNELS][3];
	logic [31:0]          rx_q  [CHANNELS][3];
	logic [7:0]           mode_q [CHANNELS];
	logic [7:0]           local_q [CHANNELS];
	logic [7:0]           far_q [CHANNELS];

	// Command decode helpers.
	function automatic logic is_stop(input logic [15:0] c);
		return c[slcc_pkg::CMD_XFER_BIT] == 1'b0 && c[11:8] == slcc_pkg::CMD_TYPE_STOP;
	endfunction : is_stop

	function automatic logic is_start(input logic [15:0] c);
		return c[slcc_pkg::CMD_XFER_BIT] == 1'b0
			&& (c[11:8] == slcc_pkg::CMD_TYPE_NORMAL || c[11:8] == slcc_pkg::CMD_TYPE_SETUP);
	endfunction : is_start

	function automatic logic is_xfer(input logic [15:0] c);
		return c[slcc_pkg::CMD_XFER_BIT] && !c[slcc_pkg::CMD_STARTSTOP];
	endfunction : is_xfer

	function automatic logic is_chan(input logic [7:0] a);
		return a >= slcc_pkg::OFF_CHAN_BASE
			&& (32'(a - slcc_pkg::OFF_CHAN_BASE) >> slcc_pkg::CHAN_STRIDE_LOG) < 32'(CHANNELS);
	endfunction : is_chan

	function automatic int chan_of(input logic [7:0] a);
		return int'(8'(a - slcc_pkg::OFF_CHAN_BASE) >> slcc_pkg::CHAN_STRIDE_LOG);
	endfunction : chan_of

	logic                cmd_wr;
	logic                halt_req;
	logic                accept;
	logic                do_halt;
	logic                do_stop;
	logic                do_start;
	logic                do_xfer;
	logic [CHANNELS-1:0] cmd_mask;
	logic [CHANNELS-1:0] stop_mask;
	logic [CHANNELS-1:0] done_now;
	logic [CHANNELS-1:0] ok_now;
	logic [CHANNELS-1:0] next_pend;
	logic [CHANNELS-1:0] next_fail;
	logic                timed_out;
	logic                finish;

	assign cmd_wr    = reg_wr && reg_addr == slcc_pkg::OFF_COMMAND && !reg_wdata[slcc_pkg::CMD_IGNORE_BIT];
	assign halt_req  = reg_wdata[15:0] == slcc_pkg::CMD_HALT_ALL;
	// Halt-all may always be written; anything else waits for a clear register.
	assign accept    = cmd_wr && (halt_req || (state == slcc_pkg::CMD_IDLE && cmd_q == slcc_pkg::RST_COMMAND));
	assign do_halt   = accept && halt_req;
	assign do_stop   = accept && !halt_req && is_stop(reg_wdata[15:0]);
	assign do_start  = accept && is_start(reg_wdata[15:0]);
	assign do_xfer   = accept && is_xfer(reg_wdata[15:0]);
	assign cmd_mask  = reg_wdata[CHANNELS-1:0];
	assign stop_mask = do_halt ? {CHANNELS{1'b1}} : (do_stop ? cmd_mask : '0);
	assign done_now  = pend & link_done;
	assign ok_now    = done_now & link_ok;
	assign next_pend = pend & ~link_done;
	assign timed_out = tmo_cnt == TMO_LAST;
	assign next_fail = fail | (done_now & ~link_ok) | (timed_out ? next_pend : '0);
	assign finish    = state != slcc_pkg::CMD_IDLE && !do_halt && (next_pend == '0 || timed_out);

	// Command register, sequencer and data register.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state   <= slcc_pkg::CMD_IDLE;
			cmd_q   <= slcc_pkg::RST_COMMAND;
			data_q  <= slcc_pkg::RST_DATA;
			pend    <= '0;
			fail    <= '0;
			tmo_cnt <= '0;
		end else if (accept) begin
			cmd_q   <= reg_wdata[15:0];
			pend    <= (do_start || do_xfer) ? cmd_mask : '0;
			fail    <= '0;
			tmo_cnt <= '0;
			if (do_start) begin
				state <= slcc_pkg::CMD_START;
			end else if (do_xfer) begin
				state <= slcc_pkg::CMD_XFER;
			end else begin
				state <= slcc_pkg::CMD_IDLE;
			end
		end else if (finish) begin
			state  <= slcc_pkg::CMD_IDLE;
			cmd_q  <= slcc_pkg::RST_COMMAND;
			data_q <= 8'(next_fail);
			pend   <= '0;
		end else if (state != slcc_pkg::CMD_IDLE) begin
			pend    <= next_pend;
			fail    <= next_fail;
			tmo_cnt <= tmo_cnt + 32'h0000_0001;
		end else if (cmd_q != slcc_pkg::RST_COMMAND) begin
			// Stops and local operations finish one cycle after acceptance.
			cmd_q <= slcc_pkg::RST_COMMAND;
		end
	end

	// Start, transfer and stop requests are one-cycle pulses; setup mode and discover are held from one start to the next.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			link_start      <= '0;
			link_xfer       <= '0;
			link_stop       <= '0;
			link_setup_mode <= 1'b0;
			link_discover   <= 1'b0;
		end else begin
			link_start <= do_start ? cmd_mask : '0;
			link_xfer  <= do_xfer ? cmd_mask : '0;
			link_stop  <= stop_mask;
			if (do_start) begin
				link_setup_mode <= reg_wdata[11:8] == slcc_pkg::CMD_TYPE_SETUP;
				// Discovery only runs against an engine with no channel running.
				link_discover   <= active == '0;
			end
		end
	end

	// Channel run state; a selective stop leaves identity and far fault validity alone.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			active    <= '0;
			setup     <= '0;
			ident_ok  <= '0;
			far_valid <= '0;
		end else if (do_halt) begin
			active    <= '0;
			setup     <= '0;
			ident_ok  <= '0;
			far_valid <= '0;
		end else if (do_stop) begin
			active <= active & ~cmd_mask;
		end else if (state == slcc_pkg::CMD_START) begin
			active    <= active | ok_now;
			setup     <= (setup & ~ok_now) | (cmd_q[11:8] == slcc_pkg::CMD_TYPE_SETUP ? ok_now : '0);
			ident_ok  <= ident_ok | ok_now;
			far_valid <= FAR_AT_START ? (far_valid | ok_now) : (far_valid & ~ok_now);
		end else if (state == slcc_pkg::CMD_XFER) begin
			far_valid <= far_valid | ok_now;
		end
	end

	// Per-channel storage.
	always_ff @(posedge sys_clk) begin
		for (int ch = 0; ch < CHANNELS; ch++) begin
			if (srst || do_halt) begin
				mode_q[ch] <= slcc_pkg::RST_BYTE;
				far_q[ch]  <= slcc_pkg::RST_BYTE;
				for (int k = 0; k < 3; k++) begin
					out_q[ch][k] <= slcc_pkg::RST_WORD;
					rx_q[ch][k]  <= slcc_pkg::RST_WORD;
				end
			end else begin
				if (reg_wr && is_chan(reg_addr) && chan_of(reg_addr) == ch) begin
					case (reg_addr[3:0])
						slcc_pkg::OFF_XFER_WORD0: out_q[ch][0] <= reg_wdata;
						slcc_pkg::OFF_XFER_WORD1: out_q[ch][1] <= reg_wdata;
						slcc_pkg::OFF_XFER_WORD2: out_q[ch][2] <= reg_wdata;
						slcc_pkg::OFF_CTRL_STAT: begin
							// A channel running in normal mode takes no mode change.
							if (!active[ch] || setup[ch]) begin
								mode_q[ch] <= reg_wdata[31:24];
							end
						end
						default: begin
						end
					endcase
				end
				if (ok_now[ch]) begin
					// Start loads unit, name and table pointers; a transfer loads process data.
					for (int k = 0; k < 3; k++) begin
						rx_q[ch][k] <= link_rx_data[ch*96 + k*32 +: 32];
					end
					far_q[ch] <= link_far_fault[ch*8 +: 8];
				end
			end
		end
	end

	// Sticky local faults: only a stop clears them, and a new event wins over the clear.
	always_ff @(posedge sys_clk) begin
		for (int ch = 0; ch < CHANNELS; ch++) begin
			if (srst) begin
				local_q[ch] <= slcc_pkg::RST_BYTE;
			end else begin
				local_q[ch] <= (stop_mask[ch] ? slcc_pkg::RST_BYTE : local_q[ch])
					| link_fault_evt[ch*8 +: 8];
			end
		end
	end

	always_comb begin
		for (int ch = 0; ch < CHANNELS; ch++) begin
			for (int k = 0; k < 3; k++) begin
				link_tx_data[ch*96 + k*32 +: 32] = out_q[ch][k];
			end
			link_mode[ch*8 +: 8] = mode_q[ch];
		end
	end

	// Status byte built from the channel's own state.
	function automatic logic [7:0] status_byte(input int ch);
		logic [7:0] s;
		s = 8'h00;
		s[slcc_pkg::ST_NOT_READY]  = !active[ch];
		s[slcc_pkg::ST_NO_IDENT]   = !ident_ok[ch];
		s[slcc_pkg::ST_LINK_ERROR] = link_error[ch];
		s[slcc_pkg::ST_FAR_FAULT]  = far_valid[ch] && far_q[ch] != slcc_pkg::RST_BYTE;
		return s;
	endfunction : status_byte

	// A zero contents pointer means the far device offers no table to walk.
	function automatic logic has_table(input int ch);
		return rx_q[ch][2][15:0] != slcc_pkg::TABLE_SENTINEL;
	endfunction : has_table

	// Read data stand in the cycle after the read strobe only.
	int rd_ch;
	assign rd_ch = chan_of(reg_addr);
	always_ff @(posedge sys_clk) begin
		if (srst || !reg_rd) begin
			reg_rdata <= slcc_pkg::RST_WORD;
		end else if (reg_addr == slcc_pkg::OFF_COMMAND) begin
			reg_rdata <= {16'h0000, cmd_q};
		end else if (reg_addr == slcc_pkg::OFF_DATA) begin
			reg_rdata <= {24'h00_0000, data_q};
		end else if (is_chan(reg_addr)) begin
			case (reg_addr[3:0])
				slcc_pkg::OFF_XFER_WORD0: reg_rdata <= rx_q[rd_ch][0];
				slcc_pkg::OFF_XFER_WORD1: reg_rdata <= rx_q[rd_ch][1];
				slcc_pkg::OFF_XFER_WORD2: reg_rdata <= rx_q[rd_ch][2];
				slcc_pkg::OFF_CTRL_STAT: begin
					reg_rdata <= {far_valid[rd_ch] ? far_q[rd_ch] : slcc_pkg::RST_BYTE,
						link_state[rd_ch*8 +: 8], status_byte(rd_ch), local_q[rd_ch]};
				end
				default: reg_rdata <= slcc_pkg::RST_WORD;
			endcase
		end else begin
			reg_rdata <= slcc_pkg::RST_WORD;
		end
	end

	// Helper for the zero-pointer check below.
	logic table_ch0;
	assign table_ch0 = has_table(0);

	a_halt_clears: assert property (@(posedge sys_clk) disable iff (srst)
		do_halt |=> active == '0 ##1 cmd_q == slcc_pkg::RST_COMMAND)
		else $error("halt-all did not stop channels and clear the command");

	a_ignore_bit31: assert property (@(posedge sys_clk) disable iff (srst)
		(reg_wr && reg_addr == slcc_pkg::OFF_COMMAND && reg_wdata[31] && state == slcc_pkg::CMD_IDLE
			&& cmd_q == slcc_pkg::RST_COMMAND) |=> cmd_q == slcc_pkg::RST_COMMAND && state == slcc_pkg::CMD_IDLE)
		else $error("ignored command write had an effect");

	a_stop_keeps_vars: assert property (@(posedge sys_clk) disable iff (srst)
		do_stop |=> rx_q[0][0] == $past(rx_q[0][0]) && ident_ok == $past(ident_ok))
		else $error("selective stop reset channel variables");

	a_stop_mask: assert property (@(posedge sys_clk) disable iff (srst)
		do_stop |=> (active & $past(cmd_mask)) == '0 && link_stop == $past(cmd_mask))
		else $error("selective stop did not stop the flagged channels");

	a_xfer_done: assert property (@(posedge sys_clk) disable iff (srst)
		(finish && state == slcc_pkg::CMD_XFER) |=> cmd_q == slcc_pkg::RST_COMMAND && data_q == 8'($past(next_fail)))
		else $error("transfer completion did not clear command and post the mask");

	a_busy_holds: assert property (@(posedge sys_clk) disable iff (srst)
		(state != slcc_pkg::CMD_IDLE && !finish && !accept) |=> cmd_q == $past(cmd_q))
		else $error("command register changed before completion");

	a_timeout_bound: assert property (@(posedge sys_clk) disable iff (srst)
		(state != slcc_pkg::CMD_IDLE) |-> tmo_cnt <= TMO_LAST)
		else $error("command ran past its timeout");

	a_xfer_request: assert property (@(posedge sys_clk) disable iff (srst)
		do_xfer |=> link_xfer == $past(cmd_mask) ##1 link_xfer == '0)
		else $error("transfer request pulse wrong");

	a_cs_normal_ro: assert property (@(posedge sys_clk) disable iff (srst)
		(reg_wr && reg_addr == (slcc_pkg::OFF_CHAN_BASE | 8'(slcc_pkg::OFF_CTRL_STAT)) && active[0] && !setup[0]
			&& !do_halt) |=> mode_q[0] == $past(mode_q[0]))
		else $error("status word write took effect in normal mode");

	a_start_loads: assert property (@(posedge sys_clk) disable iff (srst)
		(state == slcc_pkg::CMD_START && ok_now[0] && !do_halt) |=> rx_q[0][1] == $past(link_rx_data[63:32]) && active[0])
		else $error("start did not load identity words");

	a_table_sentinel: assert property (@(posedge sys_clk) disable iff (srst)
		(ok_now[0] && !do_halt) |=> table_ch0 == ($past(link_rx_data[79:64]) != slcc_pkg::TABLE_SENTINEL))
		else $error("zero pointer taken as a table");

	a_local_sticky: assert property (@(posedge sys_clk) disable iff (srst)
		(!stop_mask[0] && local_q[0] != 8'h00) |=> (local_q[0] & $past(local_q[0])) == $past(local_q[0]))
		else $error("local fault flag cleared without a stop");

	a_read_cmd: assert property (@(posedge sys_clk) disable iff (srst)
		(reg_rd && reg_addr == slcc_pkg::OFF_COMMAND) |=> reg_rdata == {16'h0000, $past(cmd_q)})
		else $error("command readback wrong");

endmodule : slcc_channel_control

// ### tb/slcc_far_model.sv
// Behavioural far-side model: one remote field device per link channel.
`timescale 1ns/10ps
module slcc_far_model #(
	parameter int N   = 2,
	parameter int DLY = 3
) (
	input  wire logic            sys_clk,
	input  wire logic            srst,
	input  wire logic [N-1:0]    link_start,
	input  wire logic [N-1:0]    link_xfer,
	input  wire logic [N-1:0]    link_stop,
	input  wire logic [N*96-1:0] link_tx_data,
	input  wire logic [N-1:0]    fail,
	input  wire logic [N-1:0]    mute,
	output logic      [N-1:0]    link_done,
	output logic      [N-1:0]    link_ok,
	output logic      [N*96-1:0] link_rx_data,
	output logic      [N*8-1:0]  link_state,
	output logic      [N-1:0]    link_error,
	output logic      [N*8-1:0]  link_far_fault
);
	logic [7:0]   cnt [N];
	logic [N-1:0] is_xfer;
	logic [95:0]  val [N];
	// A muted device never answers, so the engine has to fall back on its timeout.
	always_ff @(posedge sys_clk) begin
		for (int c = 0; c < N; c++) begin
			link_done[c] <= 1'b0;
			if (srst || link_stop[c]) begin
				cnt[c]     <= 8'h00;
				is_xfer[c] <= 1'b0;
			end else if ((link_start[c] || link_xfer[c]) && !mute[c]) begin
				cnt[c]     <= 8'(DLY);
				is_xfer[c] <= link_xfer[c];
			end else if (cnt[c] == 8'h01) begin
				cnt[c]       <= 8'h00;
				link_done[c] <= 1'b1;
			end else if (cnt[c] != 8'h00) begin
				cnt[c] <= cnt[c] - 8'h01;
			end
		end
	end
	// Outside the answer cycle the data lines show the inverse, so stale values never pass for fresh ones.
	always_comb begin
		for (int c = 0; c < N; c++) begin
			val[c] = is_xfer[c] ? ~link_tx_data[c*96 +: 96]
				: {16'h0040, 16'(16'h0080 + c), 32'h4B4E_4C46, 32'(32'h0000_0100 + c)};
			link_rx_data[c*96 +: 96] = link_done[c] ? val[c] : ~val[c];
			// A different far fault byte after a transfer shows whether the transfer reloaded it.
			link_far_fault[c*8 +: 8] = is_xfer[c] ? 8'h42 : 8'h81;
		end
	end
	assign link_ok        = ~fail;
	assign link_error     = fail;
	assign link_state     = {N{8'h30}};
endmodule : slcc_far_model

// ### tb/test_serial_link_channel_control.sv
// Self-checking bench for the serial link channel control block.
`timescale 1ns/10ps
module test_serial_link_channel_control;
	localparam int N  = 2;
	localparam int TO = 20;
	localparam logic [7:0] CMD = slcc_pkg::OFF_COMMAND;
	localparam logic [7:0] DAT = slcc_pkg::OFF_DATA;
	localparam logic [3:0] CS  = slcc_pkg::OFF_CTRL_STAT;
	logic            sys_clk = 1'b0;
	logic            srst = 1'b1;
	logic [7:0]      reg_addr = 8'h00;
	logic [31:0]     reg_wdata = 32'h0000_0000;
	logic            reg_wr = 1'b0;
	logic            reg_rd = 1'b0;
	logic [N*8-1:0]  link_fault_evt = '0;
	logic [N-1:0]    fail = '0;
	logic [N-1:0]    mute = '0;
	logic [31:0]     reg_rdata;
	logic [31:0]     v;
	logic [N-1:0]    link_start, link_xfer, link_stop, link_done, link_ok, link_error;
	logic            link_setup_mode, link_discover;
	logic [N*96-1:0] link_tx_data, link_rx_data;
	logic [N*8-1:0]  link_mode, link_state, link_far_fault;
	int              n_mismatch = 0;
	int              tests_run = 0;
	int              cyc = 0;
	time             t0;

	always #20 sys_clk = ~sys_clk;

	slcc_channel_control #(.CHANNELS(N), .ENGINE_REV(29), .TIMEOUT_CYCLES(TO)) uut (
		.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_start(link_start), .link_setup_mode(link_setup_mode),
		.link_discover(link_discover), .link_xfer(link_xfer), .link_stop(link_stop),
		.link_tx_data(link_tx_data), .link_mode(link_mode), .link_done(link_done), .link_ok(link_ok),
		.link_rx_data(link_rx_data), .link_state(link_state), .link_error(link_error),
		.link_fault_evt(link_fault_evt), .link_far_fault(link_far_fault));

	slcc_far_model #(.N(N), .DLY(3)) far (
		.sys_clk(sys_clk), .srst(srst), .link_start(link_start), .link_xfer(link_xfer),
		.link_stop(link_stop), .link_tx_data(link_tx_data), .fail(fail), .mute(mute),
		.link_done(link_done), .link_ok(link_ok), .link_rx_data(link_rx_data), .link_state(link_state),
		.link_error(link_error), .link_far_fault(link_far_fault));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : rd

	// The poll bound turns a command that never completes into a reported mismatch.
	task automatic wait_idle;
		int k;
		k = 0;
		rd(CMD, v);
		while (v !== 32'h0000_0000 && k < 200) begin
			rd(CMD, v);
			k++;
		end
		check(v, 32'h0000_0000);
	endtask : wait_idle

	function automatic logic [7:0] ca(input int c, input logic [3:0] o);
		return slcc_pkg::OFF_CHAN_BASE + 8'(c * 16) + {4'h0, o};
	endfunction : ca

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			complete_run();
		end
	end

	initial begin
		fail <= 2'b10;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		rd(CMD, v);
		check(v, 32'h0000_0000);
		rd(ca(0, CS), v);
		check(v, 32'h0030_C000);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, v);
		check(v, 32'h0000_0000);
		$display("test reset and map done");
		wr(CMD, 32'h0000_0800);
		wait_idle();
		wr(ca(0, CS), 32'h0500_0000);
		wr(ca(1, CS), 32'h0000_0000);
		check({24'h0, link_mode[7:0]}, 32'h0000_0005);
		wr(CMD, 32'h0000_0903);
		rd(CMD, v);
		check(v, 32'h0000_0903);
		wait_idle();
		rd(DAT, v);
		check(v, 32'h0000_0002);
		rd(ca(0, slcc_pkg::OFF_XFER_WORD0), v);
		check(v, 32'h0000_0100);
		rd(ca(0, slcc_pkg::OFF_XFER_WORD1), v);
		check(v, 32'h4B4E_4C46);
		rd(ca(0, slcc_pkg::OFF_XFER_WORD2), v);
		check(v, 32'h0040_0080);
		check({31'h0, link_discover}, 32'h0000_0001);
		check({31'h0, link_setup_mode}, 32'h0000_0000);
		rd(ca(0, CS), v);
		check(v & 32'hFFFF_2000, 32'h8130_0000);
		rd(ca(1, CS), v);
		check({31'h0, v[13]}, 32'h0000_0001);
		wr(ca(0, CS), 32'hFF00_0000);
		@(negedge sys_clk);
		check({24'h0, link_mode[7:0]}, 32'h0000_0005);
		wr(CMD, 32'h0000_0901);
		wait_idle();
		check({31'h0, link_discover}, 32'h0000_0000);
		wr(CMD, 32'h8000_0901);
		rd(CMD, v);
		check(v, 32'h0000_0000);
		$display("test start done");
		for (int k = 0; k < 3; k++) begin
			wr(ca(0, 4'(k * 4)), 32'h1234_5670 + 32'(k));
		end
		wr(CMD, 32'h0000_1001);
		wait_idle();
		rd(DAT, v);
		check(v, 32'h0000_0000);
		for (int k = 0; k < 3; k++) begin
			rd(ca(0, 4'(k * 4)), v);
			check(v, ~(32'h1234_5670 + 32'(k)));
		end
		rd(ca(0, CS), v);
		check({24'h0, v[31:24]}, 32'h0000_0042);
		mute <= 2'b01;
		wr(CMD, 32'h0000_1001);
		t0 = $time;
		wait_idle();
		check({31'h0, ($time - t0) / 40 >= TO}, 32'h0000_0001);
		rd(DAT, v);
		check(v, 32'h0000_0001);
		mute <= 2'b00;
		$display("test transfer done");
		@(posedge sys_clk);
		link_fault_evt <= 16'h0024;
		@(posedge sys_clk);
		link_fault_evt <= 16'h0000;
		rd(ca(0, CS), v);
		check({24'h0, v[7:0]}, 32'h0000_0024);
		wr(CMD, 32'h0000_0802);
		wait_idle();
		rd(ca(0, CS), v);
		check({24'h0, v[7:0]}, 32'h0000_0024);
		wr(CMD, 32'h0000_0801);
		wait_idle();
		rd(ca(0, CS), v);
		check({24'h0, v[7:0]}, 32'h0000_0000);
		check({24'h0, link_mode[7:0]}, 32'h0000_0005);
		wr(CMD, 32'h0000_0800);
		wait_idle();
		check({24'h0, link_mode[7:0]}, 32'h0000_0000);
		rd(ca(0, slcc_pkg::OFF_XFER_WORD0), v);
		check(v, 32'h0000_0000);
		wr(CMD, 32'h0000_0F01);
		wait_idle();
		check({31'h0, link_setup_mode}, 32'h0000_0001);
		rd(ca(0, slcc_pkg::OFF_XFER_WORD0), v);
		check(v, 32'h0000_0100);
		$display("test stop and setup done");
		complete_run();
	end
endmodule : test_serial_link_channel_control
